// >>> include/csu_regs.svh
// Register offsets, reset values and decode constants of the clock source unit
`ifndef CSU_REGS_SVH
`define CSU_REGS_SVH

`define CSU_ADDR_W          8
`define CSU_OFF_CTRL1       8'h00
`define CSU_OFF_CTRL2       8'h04
`define CSU_RST_CTRL1       8'h04
`define CSU_RST_CTRL2       8'h40
`define CSU_RST_BUS_DIV     4'h2
`define CSU_RST_REF_DIV     11'h001
`define CSU_SRC_FLL         2'h0
`define CSU_SRC_INT         2'h1
`define CSU_SRC_EXT         2'h2
`define CSU_SRC_RSVD        2'h3
`define CSU_REFDIV_HI_OFFSET 4'h5
`define CSU_REFDIV_HI_LAST   3'h5
`define CSU_REFDIV_HI_CLAMP  4'ha

`endif

// >>> include/csu_pkg.sv
// Types shared by the clock source unit control logic
package csu_pkg;

  typedef struct packed {
    logic [1:0] bus_source_select;
    logic [2:0] reference_divider;
    logic       fll_reference_select;
    logic       internal_ref_out_enable;
    logic       internal_ref_stop_keep;
  } csu_ctrl1_t;

  typedef struct packed {
    logic [1:0] bus_clock_divider;
    logic       osc_range_high;
    logic       oscillator_gain_select;
    logic       fll_bypass_power_down;
    logic       external_source_request;
    logic       external_ref_out_enable;
    logic       external_ref_stop_keep;
  } csu_ctrl2_t;

  typedef enum logic [2:0] {
    CSU_LOOP_INT,
    CSU_LOOP_EXT,
    CSU_BYP_INT,
    CSU_BYP_INT_OFF,
    CSU_BYP_EXT,
    CSU_BYP_EXT_OFF,
    CSU_STOP
  } csu_mode_t;

  // Settings handed to the clock generation logic
  typedef struct packed {
    logic [1:0]  bus_source;
    logic [3:0]  bus_div_factor;
    logic [10:0] ref_div_factor;
    logic        ref_div_reserved;
    logic        fll_ref_internal;
    logic        fll_enable;
    logic        internal_ref_clock_out;
    logic        external_ref_clock_out;
    logic        osc_range_high;
    logic        oscillator_gain_select;
    logic        external_source_request;
  } csu_clk_cfg_t;

endpackage : csu_pkg

// >>> hdl/csu_stop_keep.sv
// Decides whether a reference clock keeps running through stop
`timescale 1ns/1ps
`default_nettype none
module csu_stop_keep (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic stop_mode,
  input  wire logic ref_enable,
  input  wire logic ref_stop_keep,
  output logic      keep_now
);
  import csu_pkg::*;

  typedef struct packed {
    logic stop_prev;
    logic keep;
  } csu_keep_state_t;

  csu_keep_state_t state_reg;
  csu_keep_state_t state_next;
  logic            stop_entry;

  // Enable is judged as it stood when stop began, later writes cannot revive it
  always_comb begin
    state_next           = state_reg;
    stop_entry           = stop_mode && !state_reg.stop_prev;
    state_next.stop_prev = stop_mode;
    if (!stop_mode) begin
      state_next.keep = 1'b0;
    end else if (stop_entry) begin
      state_next.keep = ref_enable && ref_stop_keep;
    end
    keep_now = stop_mode && state_next.keep;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : csu_stop_keep
`default_nettype wire

// >>> hdl/csu_ctrl.sv
// APB control registers of the clock source unit
// Notes on behaviour
// - Source select 00 picks the FLL, 01 the internal reference, 10 the external one, and 11 acts as 00.
// - In low range the reference divider codes 0 to 7 divide by 1 to 128 in powers of two, code 0 at reset.
// - In high range codes 0 to 5 divide by 32 to 1024, and codes 6 and 7 are reserved.
// - The reference select bit picks the internal reference for the FLL when 1, the external when 0.
// - The internal reference output enable gates the internal reference clock output.
// - In stop the internal reference runs only if its stop keep bit and its enable were set on entry.
// - The bus divider codes 00 to 11 divide by 1, 2, 4 and 8, with 01 at reset.
// - The range bit selects the high oscillator range and the high column of reference factors.
// - The gain bit selects high gain operation when 1 and low power operation when 0.
// - The low power bit switches the FLL off in bypassed modes unless background debug is active.
// - The external source bit requests the crystal oscillator when 1 and an external clock when 0.
// - The external reference output enable gates the external reference clock output.
// - In stop the external source runs only if its stop keep bit and its enable were set on entry.
// - Out of reset the unit is in FLL engaged internal mode with the internal reference.
`timescale 1ns/1ps
`default_nettype none
`include "csu_regs.svh"
module csu_ctrl (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`CSU_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  input  wire logic                     stop_mode,
  input  wire logic                     background_debug_mode,
  output csu_pkg::csu_clk_cfg_t         clk_cfg,
  output csu_pkg::csu_mode_t            clock_mode
);
  import csu_pkg::*;

  typedef struct packed {
    csu_ctrl1_t   ctrl1;
    csu_ctrl2_t   ctrl2;
    logic         ready;
    logic         slverr;
    logic [31:0]  rdata;
    csu_clk_cfg_t cfg;
    csu_mode_t    mode;
  } csu_state_t;

  csu_state_t state_reg;
  csu_state_t state_next;
  logic       irc_keep;
  logic       erc_keep;
  logic       setup;
  logic       access_done;
  logic       hit1;
  logic       hit2;
  logic       bypassed;

  function automatic logic [3:0] bus_div_of(input logic [1:0] code);
    bus_div_of = 4'h1 << code;
  endfunction : bus_div_of

  // Reserved high range codes clamp to the largest factor rather than wrapping
  function automatic logic [10:0] ref_div_of(input logic [2:0] code, input logic high);
    logic [3:0] shift;
    shift = {1'b0, code};
    if (high) begin
      shift = (code > `CSU_REFDIV_HI_LAST) ? `CSU_REFDIV_HI_CLAMP
                                           : 4'(shift + `CSU_REFDIV_HI_OFFSET);
    end
    ref_div_of = 11'h1 << shift;
  endfunction : ref_div_of

  function automatic logic [1:0] src_of(input logic [1:0] code);
    src_of = (code == `CSU_SRC_RSVD) ? `CSU_SRC_FLL : code;
  endfunction : src_of

  csu_stop_keep u_irc_keep (
    .pclk          (pclk),
    .presetn       (presetn),
    .stop_mode     (stop_mode),
    .ref_enable    (state_reg.ctrl1.internal_ref_out_enable),
    .ref_stop_keep (state_reg.ctrl1.internal_ref_stop_keep),
    .keep_now      (irc_keep)
  );

  csu_stop_keep u_erc_keep (
    .pclk          (pclk),
    .presetn       (presetn),
    .stop_mode     (stop_mode),
    .ref_enable    (state_reg.ctrl2.external_ref_out_enable),
    .ref_stop_keep (state_reg.ctrl2.external_ref_stop_keep),
    .keep_now      (erc_keep)
  );

  always_comb begin
    state_next  = state_reg;
    setup       = psel && !penable;
    access_done = psel && penable && state_reg.ready;
    hit1        = (paddr == `CSU_OFF_CTRL1);
    hit2        = (paddr == `CSU_OFF_CTRL2);

    // One wait-free access cycle: answer is prepared in setup and shown in access
    state_next.ready  = 1'b0;
    state_next.slverr = 1'b0;
    if (setup) begin
      state_next.ready  = 1'b1;
      state_next.slverr = !(hit1 || hit2);
      state_next.rdata  = '0;
      if (hit1) begin
        state_next.rdata[7:0] = state_reg.ctrl1;
      end else if (hit2) begin
        state_next.rdata[7:0] = state_reg.ctrl2;
      end
    end
    if (access_done && pwrite) begin
      if (hit1) begin
        state_next.ctrl1 = pwdata[7:0];
      end else if (hit2) begin
        state_next.ctrl2 = pwdata[7:0];
      end
    end

    // Settings follow the next register values so they change at the write edge
    bypassed = (src_of(state_next.ctrl1.bus_source_select) != `CSU_SRC_FLL);
    state_next.cfg.bus_source       = src_of(state_next.ctrl1.bus_source_select);
    state_next.cfg.bus_div_factor   = bus_div_of(state_next.ctrl2.bus_clock_divider);
    state_next.cfg.ref_div_factor   = ref_div_of(state_next.ctrl1.reference_divider,
                                                 state_next.ctrl2.osc_range_high);
    state_next.cfg.ref_div_reserved = state_next.ctrl2.osc_range_high
                                      && (state_next.ctrl1.reference_divider > `CSU_REFDIV_HI_LAST);
    state_next.cfg.fll_ref_internal = state_next.ctrl1.fll_reference_select;
    state_next.cfg.osc_range_high   = state_next.ctrl2.osc_range_high;
    state_next.cfg.oscillator_gain_select  = state_next.ctrl2.oscillator_gain_select;
    state_next.cfg.external_source_request = state_next.ctrl2.external_source_request;
    state_next.cfg.fll_enable = !stop_mode
                                && !(bypassed && state_next.ctrl2.fll_bypass_power_down
                                     && !background_debug_mode);
    state_next.cfg.internal_ref_clock_out = stop_mode ? irc_keep
                                          : state_next.ctrl1.internal_ref_out_enable;
    state_next.cfg.external_ref_clock_out = stop_mode ? erc_keep
                                          : state_next.ctrl2.external_ref_out_enable;

    if (stop_mode) begin
      state_next.mode = CSU_STOP;
    end else begin
      unique case (state_next.cfg.bus_source)
        `CSU_SRC_INT: state_next.mode = state_next.cfg.fll_enable ? CSU_BYP_INT : CSU_BYP_INT_OFF;
        `CSU_SRC_EXT: state_next.mode = state_next.cfg.fll_enable ? CSU_BYP_EXT : CSU_BYP_EXT_OFF;
        default:      state_next.mode = state_next.ctrl1.fll_reference_select ? CSU_LOOP_INT : CSU_LOOP_EXT;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg                             <= '0;
      state_reg.ctrl1                       <= `CSU_RST_CTRL1;
      state_reg.ctrl2                       <= `CSU_RST_CTRL2;
      state_reg.cfg.bus_div_factor          <= `CSU_RST_BUS_DIV;
      state_reg.cfg.ref_div_factor          <= `CSU_RST_REF_DIV;
      state_reg.cfg.fll_ref_internal        <= 1'b1;
      state_reg.cfg.fll_enable              <= 1'b1;
      state_reg.mode                        <= CSU_LOOP_INT;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pready     = state_reg.ready;
  assign pslverr    = state_reg.slverr;
  assign prdata     = state_reg.rdata;
  assign clk_cfg    = state_reg.cfg;
  assign clock_mode = state_reg.mode;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_src_reserved: assert property (
    (access_done && pwrite && hit1 && pwdata[7:6] == `CSU_SRC_RSVD) |=> clk_cfg.bus_source == `CSU_SRC_FLL
  ) else $error("Reserved source code not mapped to FLL");

  a_src_follow: assert property (
    (access_done && pwrite && hit1 && pwdata[7:6] != `CSU_SRC_RSVD) |=> clk_cfg.bus_source == $past(pwdata[7:6])
  ) else $error("Source select does not follow write");

  a_refdiv_low: assert property (
    !state_reg.ctrl2.osc_range_high |-> ##1 (
      $past(state_next.ctrl2.osc_range_high) ||
      clk_cfg.ref_div_factor == (11'h1 << $past(state_next.ctrl1.reference_divider)))
  ) else $error("Low range reference factor wrong");

  a_refdiv_high: assert property (
    (state_next.ctrl2.osc_range_high && state_next.ctrl1.reference_divider == 3'h0) |=>
      clk_cfg.ref_div_factor == 11'h020 && !clk_cfg.ref_div_reserved
  ) else $error("High range code 0 not divide by 32");

  a_busdiv_factor: assert property (
    (access_done && pwrite && hit2) |=> clk_cfg.bus_div_factor == (4'h1 << $past(pwdata[7:6]))
  ) else $error("Bus divider factor wrong after write");

  a_fll_lowpow: assert property (
    (!stop_mode && !background_debug_mode && state_reg.ctrl2.fll_bypass_power_down
     && state_reg.ctrl1.bus_source_select == `CSU_SRC_INT && !access_done) |=> !clk_cfg.fll_enable
  ) else $error("FLL not off in low power bypass");

  a_fll_bdm: assert property (
    (!stop_mode && background_debug_mode) |=> clk_cfg.fll_enable
  ) else $error("FLL off while debug active");

  a_irc_stop: assert property (
    ($rose(stop_mode) && !(state_reg.ctrl1.internal_ref_out_enable && state_reg.ctrl1.internal_ref_stop_keep))
      ##1 stop_mode[*3] |-> !clk_cfg.internal_ref_clock_out
  ) else $error("Internal reference kept in stop");

  a_erc_stop: assert property (
    ($rose(stop_mode) && state_reg.ctrl2.external_ref_out_enable && state_reg.ctrl2.external_ref_stop_keep)
      |=> clk_cfg.external_ref_clock_out
  ) else $error("External source dropped in stop");

  a_erc_run: assert property (
    !stop_mode |=> clk_cfg.external_ref_clock_out == $past(state_next.ctrl2.external_ref_out_enable)
  ) else $error("External reference output not gated by enable");

  a_irc_run: assert property (
    !stop_mode |=> clk_cfg.internal_ref_clock_out == $past(state_next.ctrl1.internal_ref_out_enable)
  ) else $error("Internal reference output not gated by enable");

  a_reg_write: assert property (
    (access_done && pwrite && hit2) |=> state_reg.ctrl2 == $past(pwdata[7:0])
  ) else $error("Register write not stored");

  a_ready_one: assert property (
    setup |=> pready ##1 !pready
  ) else $error("Access phase not one cycle");

  a_mode_engaged: assert property (
    (!stop_mode && state_next.ctrl1.bus_source_select == `CSU_SRC_FLL && state_next.ctrl1.fll_reference_select)
      |=> clock_mode == CSU_LOOP_INT && clk_cfg.fll_ref_internal
  ) else $error("Engaged internal mode not shown");

  c_write_ctrl1: cover property (access_done && pwrite && hit1);
  c_read_ctrl2:  cover property (access_done && !pwrite && hit2);
  c_stop_keep:   cover property ($rose(stop_mode) ##1 clk_cfg.internal_ref_clock_out);
  c_byp_int_off: cover property (clock_mode == CSU_BYP_INT_OFF);

endmodule : csu_ctrl
`default_nettype wire

// >>> testbench/test_csu_ctrl.sv
// Self-checking testbench of the clock source unit control registers
`timescale 1ns/1ps
`default_nettype none
`include "csu_regs.svh"
module test_csu_ctrl;
  import csu_pkg::*;
  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [`CSU_ADDR_W-1:0] paddr;
  logic [31:0]            pwdata;
  logic                   pready;
  logic [31:0]            prdata;
  logic                   pslverr;
  logic                   stop_mode;
  logic                   background_debug_mode;
  csu_clk_cfg_t           cfg;
  csu_mode_t              mode;
  logic [31:0]            rd;
  logic                   err;
  int                     mismatches = 0;
  int                     samples_checked = 0;
  csu_mode_t              src_mode [4] = '{CSU_LOOP_INT, CSU_BYP_INT, CSU_BYP_EXT, CSU_LOOP_INT};

  csu_ctrl DUT (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .pready                (pready),
    .prdata                (prdata),
    .pslverr               (pslverr),
    .stop_mode             (stop_mode),
    .background_debug_mode (background_debug_mode),
    .clk_cfg               (cfg),
    .clock_mode            (mode)
  );

  always #25 pclk = ~pclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bounded wait on pready so a dead slave cannot hang the bus
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, 32'(pready));
  endtask : apb

  // Ends mid-cycle so outputs of the write edge have settled
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    apb(1'b1, addr, data);
    @(negedge pclk);
  endtask : wr

  task automatic chk_rd(input logic [7:0] addr, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, addr, 32'h0);
    chk("read data", exp, rd);
    chk("slave error", 32'(exp_err), 32'(err));
  endtask : chk_rd

  task automatic drv(input logic s, input logic d);
    @(posedge pclk);
    stop_mode             <= s;
    background_debug_mode <= d;
    repeat (2) @(negedge pclk);
  endtask : drv

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    stop_test();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    stop_mode = 1'b0;
    background_debug_mode = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("bus source", 32'h0, 32'(cfg.bus_source));
    chk("bus divide", 32'h2, 32'(cfg.bus_div_factor));
    chk("ref divide", 32'h1, 32'(cfg.ref_div_factor));
    chk("fll ref", 32'h1, 32'(cfg.fll_ref_internal));
    chk("fll enable", 32'h1, 32'(cfg.fll_enable));
    chk("mode", 32'(CSU_LOOP_INT), 32'(mode));
    chk_rd(`CSU_OFF_CTRL1, 32'h04, 1'b0);
    chk_rd(`CSU_OFF_CTRL2, 32'h40, 1'b0);
    for (int s = 0; s < 4; s++) begin
      wr(`CSU_OFF_CTRL1, 32'(s << 6) | 32'h04);
      chk("bus source", (s == 3) ? 32'h0 : 32'(s), 32'(cfg.bus_source));
      chk("mode", 32'(src_mode[s]), 32'(mode));
      chk("fll enable", 32'h1, 32'(cfg.fll_enable));
    end
    for (int r = 0; r < 2; r++) begin
      wr(`CSU_OFF_CTRL2, (r == 1) ? 32'h60 : 32'h40);
      chk("osc range", 32'(r), 32'(cfg.osc_range_high));
      for (int d = 0; d < 8; d++) begin
        wr(`CSU_OFF_CTRL1, 32'h04 | 32'(d << 3));
        chk("ref divide", (r == 1) ? ((d > 5) ? 32'd1024 : 32'd32 << d) : 32'd1 << d,
            32'(cfg.ref_div_factor));
        chk("ref reserved", 32'(r == 1 && d > 5), 32'(cfg.ref_div_reserved));
        chk_rd(`CSU_OFF_CTRL1, 32'h04 | 32'(d << 3), 1'b0);
      end
    end
    // Divided 8 MHz crystal, scaled by 16, must sit in the allowed reference band
    wr(`CSU_OFF_CTRL1, 32'h1c);
    chk("ref in band", 32'h1, 32'(32'd128_000_000 / cfg.ref_div_factor inside {[32'd500_000:32'd625_000]}));
    for (int b = 0; b < 4; b++) begin
      wr(`CSU_OFF_CTRL2, 32'(b << 6));
      chk("bus divide", 32'd1 << b, 32'(cfg.bus_div_factor));
    end
    // Upper data bits are noise and must not reach the byte
    wr(`CSU_OFF_CTRL1, 32'hab00_0002);
    chk("fll ref", 32'h0, 32'(cfg.fll_ref_internal));
    chk("mode", 32'(CSU_LOOP_EXT), 32'(mode));
    chk("int out", 32'h1, 32'(cfg.internal_ref_clock_out));
    chk_rd(`CSU_OFF_CTRL1, 32'h02, 1'b0);
    wr(`CSU_OFF_CTRL1, 32'h04);
    chk("fll ref", 32'h1, 32'(cfg.fll_ref_internal));
    chk("int out", 32'h0, 32'(cfg.internal_ref_clock_out));
    wr(`CSU_OFF_CTRL2, 32'h5a00_0016);
    chk("gain", 32'h1, 32'(cfg.oscillator_gain_select));
    chk("ext request", 32'h1, 32'(cfg.external_source_request));
    chk("ext out", 32'h1, 32'(cfg.external_ref_clock_out));
    chk_rd(`CSU_OFF_CTRL2, 32'h16, 1'b0);
    wr(`CSU_OFF_CTRL2, 32'h00);
    chk("gain", 32'h0, 32'(cfg.oscillator_gain_select));
    chk("ext request", 32'h0, 32'(cfg.external_source_request));
    chk("ext out", 32'h0, 32'(cfg.external_ref_clock_out));
    wr(`CSU_OFF_CTRL2, 32'h08);
    wr(`CSU_OFF_CTRL1, 32'h44);
    chk("fll enable", 32'h0, 32'(cfg.fll_enable));
    chk("mode", 32'(CSU_BYP_INT_OFF), 32'(mode));
    drv(1'b0, 1'b1);
    chk("fll enable", 32'h1, 32'(cfg.fll_enable));
    drv(1'b0, 1'b0);
    wr(`CSU_OFF_CTRL1, 32'h84);
    chk("fll enable", 32'h0, 32'(cfg.fll_enable));
    chk("mode", 32'(CSU_BYP_EXT_OFF), 32'(mode));
    wr(`CSU_OFF_CTRL2, 32'h00);
    chk("fll enable", 32'h1, 32'(cfg.fll_enable));
    wr(`CSU_OFF_CTRL1, 32'h07);
    wr(`CSU_OFF_CTRL2, 32'h02);
    drv(1'b1, 1'b0);
    chk("mode", 32'(CSU_STOP), 32'(mode));
    chk("fll enable", 32'h0, 32'(cfg.fll_enable));
    chk("int out", 32'h1, 32'(cfg.internal_ref_clock_out));
    chk("ext out", 32'h0, 32'(cfg.external_ref_clock_out));
    wr(`CSU_OFF_CTRL2, 32'h03);
    chk("ext out", 32'h0, 32'(cfg.external_ref_clock_out));
    drv(1'b0, 1'b0);
    chk("ext out", 32'h1, 32'(cfg.external_ref_clock_out));
    chk("mode", 32'(CSU_LOOP_INT), 32'(mode));
    wr(`CSU_OFF_CTRL1, 32'h05);
    drv(1'b1, 1'b0);
    wr(`CSU_OFF_CTRL1, 32'h07);
    chk("int out", 32'h0, 32'(cfg.internal_ref_clock_out));
    chk("ext out", 32'h1, 32'(cfg.external_ref_clock_out));
    drv(1'b0, 1'b0);
    chk("int out", 32'h1, 32'(cfg.internal_ref_clock_out));
    wr(8'h08, 32'h0000_00ff);
    chk("slave error", 32'h1, 32'(err));
    chk_rd(8'h08, 32'h0, 1'b1);
    chk_rd(`CSU_OFF_CTRL1, 32'h07, 1'b0);
    chk_rd(`CSU_OFF_CTRL2, 32'h03, 1'b0);
    stop_test();
  end
endmodule : test_csu_ctrl
`default_nettype wire
